// *** verilog/isf_pkg.sv ***
// Constants of the inertial sample filter: register map, field layout,
// reset values, range codes and the base sample timing.
// Assumes a 40 MHz MCLK and a register port of 16-bit words with byte enables.
//
// Contract
// - Internal clock updates outputs at 819.2 SPS.
// - Decimation D halves update rate per step.
// - Clock-select bit: 1 internal, 0 external.
// - External clocking owns pin four over GPIO.
// - Two cascaded averaging stages form Bartlett FIR.
// - Filter size B sets 2^B taps per stage.
// - Range bits pick 300, 150, 75 deg/s.
// - Lower ranges force minimum filter sizes.
// - Bias trim added just before output load.
// - Trim is 14-bit two's complement value.
package isf_pkg;
  localparam int          DATA_W    = 16;
  localparam int          TRIM_W    = 14;
  localparam int          AXES      = 3;
  localparam int          HIST_LOG2 = 7;
  localparam int          HIST_DEPTH = 128;
  localparam int          SUM_W     = 23;
  localparam int          ACC_W     = 47;
  localparam int          DCNT_W    = 32;

  localparam logic [7:0]  ADDR_GYRO_X_TRIM  = 8'h1e;
  localparam logic [7:0]  ADDR_GYRO_Y_TRIM  = 8'h20;
  localparam logic [7:0]  ADDR_GYRO_Z_TRIM  = 8'h22;
  localparam logic [7:0]  ADDR_SAMPLE_PERIOD = 8'h3a;
  localparam logic [7:0]  ADDR_RANGE_FILTER = 8'h3c;

  localparam logic [15:0] RST_TRIM          = 16'h0000;
  localparam logic [15:0] RST_SAMPLE_PERIOD = 16'h0001;
  localparam logic [15:0] RST_RANGE_FILTER  = 16'h0402;

  localparam logic [15:0] MASK_SAMPLE_PERIOD = 16'h1f01;
  localparam logic [15:0] MASK_RANGE_FILTER  = 16'h0707;
  localparam logic [15:0] MASK_TRIM          = 16'h3fff;

  localparam int          SP_CLK_SEL   = 0;
  localparam int          SP_DECIM_LSB = 8;
  localparam int          RF_TAPS_LSB  = 0;
  localparam int          RF_RANGE_LSB = 8;

  localparam logic [2:0]  RANGE_300 = 3'h4;
  localparam logic [2:0]  RANGE_150 = 3'h2;
  localparam logic [2:0]  RANGE_75  = 3'h1;
  localparam logic [2:0]  MIN_TAPS_150 = 3'h2;
  localparam logic [2:0]  MIN_TAPS_75  = 3'h4;

  localparam real         CLK_PERIOD_NS = 25.0;
  localparam real         BASE_RATE_SPS = 819.2;
  localparam int          TICK_CYCLES   = $rtoi(1.0e9 / (BASE_RATE_SPS * CLK_PERIOD_NS));
endpackage

// *** verilog/isf_axis_filter.sv ***
// One gyroscope axis: two cascaded moving-average stages, then an averaging decimator.
// Assumes sample_valid pulses at most once per clock and settings held stable between clears.
`timescale 1ns/1ps
module isf_axis_filter (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clear,
  input  wire logic                         sample_valid,
  input  wire logic signed [isf_pkg::DATA_W-1:0] sample,
  input  wire logic [2:0]                   taps_log2,
  input  wire logic [4:0]                   decim_log2,
  output logic                              out_valid,
  output logic signed [isf_pkg::DATA_W-1:0] out_data
);
  logic signed [isf_pkg::DATA_W-1:0] st_data [0:2];
  logic                              st_v    [0:2];
  logic [7:0]                        taps;

  assign st_data[0] = sample;
  assign st_v[0]    = sample_valid;
  assign taps       = 8'h01 << taps_log2;

  ////////////////////////////////////////////////////////////////////////////
  // Cascade of two boxcars: their convolution is the triangular window
  genvar s;
  for (s = 0; s < 2; s++) begin : g_stage
    logic signed [isf_pkg::DATA_W-1:0] hist_ff [0:isf_pkg::HIST_DEPTH-1];
    logic [isf_pkg::HIST_LOG2-1:0]     ptr_ff;
    logic signed [isf_pkg::SUM_W-1:0]  sum_ff;
    logic signed [isf_pkg::SUM_W-1:0]  nxt_sum;
    logic signed [isf_pkg::DATA_W-1:0] out_ff;
    logic                              v_ff;
    logic [isf_pkg::HIST_LOG2-1:0]     old_idx;

    // Oldest sample still in the window; 128 taps wraps onto ptr itself
    assign old_idx = isf_pkg::HIST_LOG2'({1'b0, ptr_ff} - taps);
    assign nxt_sum = sum_ff + isf_pkg::SUM_W'(st_data[s]) - isf_pkg::SUM_W'(hist_ff[old_idx]);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ptr_ff <= '0;
        sum_ff <= '0;
        out_ff <= '0;
        v_ff   <= 1'b0;
        for (int i = 0; i < isf_pkg::HIST_DEPTH; i++) hist_ff[i] <= '0;
      end else if (clear) begin
        ptr_ff <= '0;
        sum_ff <= '0;
        v_ff   <= 1'b0;
        for (int i = 0; i < isf_pkg::HIST_DEPTH; i++) hist_ff[i] <= '0;
      end else begin
        v_ff <= st_v[s];
        if (st_v[s]) begin
          hist_ff[ptr_ff] <= st_data[s];
          ptr_ff          <= ptr_ff + 1'b1;
          sum_ff          <= nxt_sum;
          out_ff          <= isf_pkg::DATA_W'(nxt_sum >>> taps_log2);
        end
      end
    end
    assign st_data[s+1] = out_ff;
    assign st_v[s+1]    = v_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Averaging decimator over 2^D filter outputs
  logic [isf_pkg::DCNT_W-1:0]       cnt_ff;
  logic signed [isf_pkg::ACC_W-1:0] acc_ff;
  logic signed [isf_pkg::ACC_W-1:0] nxt_acc;
  logic [isf_pkg::DCNT_W-1:0]       last_cnt;

  assign nxt_acc  = acc_ff + isf_pkg::ACC_W'(st_data[2]);
  assign last_cnt = (32'h1 << decim_log2) - 32'h1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff    <= '0;
      acc_ff    <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (clear) begin
      cnt_ff    <= '0;
      acc_ff    <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      if (st_v[2]) begin
        if (cnt_ff >= last_cnt) begin
          out_data  <= isf_pkg::DATA_W'(nxt_acc >>> decim_log2);
          out_valid <= 1'b1;
          cnt_ff    <= '0;
          acc_ff    <= '0;
        end else begin
          cnt_ff <= cnt_ff + 32'h1;
          acc_ff <= nxt_acc;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_cascade;
    sample_valid && !clear ##1 !clear |=> st_v[2];
  endproperty
  a_cascade: assert property (p_cascade) else $error("stage two did not follow stage one");

  property p_no_decim;
    st_v[2] && !clear && decim_log2 == 5'h00 |=> out_valid;
  endproperty
  a_no_decim: assert property (p_no_decim) else $error("D of zero dropped a sample");

  property p_decim_skip;
    st_v[2] && !clear && cnt_ff < last_cnt |=> !out_valid;
  endproperty
  a_decim_skip: assert property (p_decim_skip) else $error("decimator emitted early");
endmodule

// *** verilog/isf_top.sv ***
// Gyroscope sample path: sample clock select, Bartlett filter, decimation, bias trim, registers.
// Assumes the register port and raw samples are synchronous to MCLK.
`timescale 1ns/1ps
module isf_top #(
  parameter int TICK_CYCLES = isf_pkg::TICK_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [1:0]  REG_BE,
  input  wire logic [15:0] REG_WDATA,
  output logic [15:0]      REG_RDATA,
  input  wire logic [15:0] GYRO_X_RAW,
  input  wire logic [15:0] GYRO_Y_RAW,
  input  wire logic [15:0] GYRO_Z_RAW,
  input  wire logic        PIN_FOUR_DIR,
  input  wire logic        PIN_FOUR_LEVEL,
  input  wire logic        GENERAL_PIN_FOUR_I,
  output logic             GENERAL_PIN_FOUR_O,
  output logic             GENERAL_PIN_FOUR_OE,
  output logic             SAMPLE_TICK,
  output logic [15:0]      GYRO_X_RESULT,
  output logic [15:0]      GYRO_Y_RESULT,
  output logic [15:0]      GYRO_Z_RESULT,
  output logic             RESULT_VALID
);
  logic [15:0] trim_ff [0:isf_pkg::AXES-1];
  logic [15:0] sample_period_ff;
  logic [15:0] range_filter_ff;
  logic [15:0] nxt_sample_period;
  logic [15:0] nxt_range_filter;
  logic [15:0] wr_merged;
  logic [15:0] wr_mask;
  logic [15:0] rd_value;
  logic        clk_internal;
  logic [4:0]  decim;
  logic [2:0]  taps_log2;
  logic [2:0]  cur_range;

  assign clk_internal = sample_period_ff[isf_pkg::SP_CLK_SEL];
  assign decim        = sample_period_ff[isf_pkg::SP_DECIM_LSB +: 5];
  assign taps_log2    = range_filter_ff[isf_pkg::RF_TAPS_LSB +: 3];
  assign cur_range    = range_filter_ff[isf_pkg::RF_RANGE_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, byte lanes merged onto the stored word
  assign wr_mask   = {{8{REG_BE[1]}}, {8{REG_BE[0]}}};

  always_comb begin
    logic [2:0] rng;
    logic [2:0] b;
    logic [2:0] b_min;
    rng   = 3'h0;
    b     = 3'h0;
    b_min = 3'h0;
    nxt_sample_period = ((REG_WDATA & wr_mask) | (sample_period_ff & ~wr_mask))
                        & isf_pkg::MASK_SAMPLE_PERIOD;
    wr_merged = (REG_WDATA & wr_mask) | (range_filter_ff & ~wr_mask);
    rng = wr_merged[isf_pkg::RF_RANGE_LSB +: 3];
    // Unknown range patterns keep the previous range rather than leave gain undefined
    if (rng != isf_pkg::RANGE_300 && rng != isf_pkg::RANGE_150 && rng != isf_pkg::RANGE_75) begin
      rng = cur_range;
    end
    b_min = (rng == isf_pkg::RANGE_75)  ? isf_pkg::MIN_TAPS_75 :
            (rng == isf_pkg::RANGE_150) ? isf_pkg::MIN_TAPS_150 : 3'h0;
    b = wr_merged[isf_pkg::RF_TAPS_LSB +: 3];
    // Size is raised in the register itself, so a later range write can alter it
    if (b < b_min) begin
      b = b_min;
    end
    nxt_range_filter = '0;
    nxt_range_filter[isf_pkg::RF_RANGE_LSB +: 3] = rng;
    nxt_range_filter[isf_pkg::RF_TAPS_LSB +: 3]  = b;
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sample_period_ff <= isf_pkg::RST_SAMPLE_PERIOD;
      range_filter_ff  <= isf_pkg::RST_RANGE_FILTER;
    end else if (REG_WR && REG_BE != 2'h0) begin
      if (REG_ADDR == isf_pkg::ADDR_SAMPLE_PERIOD) sample_period_ff <= nxt_sample_period;
      if (REG_ADDR == isf_pkg::ADDR_RANGE_FILTER)  range_filter_ff  <= nxt_range_filter;
    end
  end

  genvar a;
  for (a = 0; a < isf_pkg::AXES; a++) begin : g_trim
    localparam logic [7:0] TRIM_ADDR = isf_pkg::ADDR_GYRO_X_TRIM + 8'(2 * a);
    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        trim_ff[a] <= isf_pkg::RST_TRIM;
      end else if (REG_WR && REG_ADDR == TRIM_ADDR) begin
        trim_ff[a] <= ((REG_WDATA & wr_mask) | (trim_ff[a] & ~wr_mask)) & isf_pkg::MASK_TRIM;
      end
    end
  end

  always_comb begin
    unique case (REG_ADDR)
      isf_pkg::ADDR_GYRO_X_TRIM:   rd_value = trim_ff[0];
      isf_pkg::ADDR_GYRO_Y_TRIM:   rd_value = trim_ff[1];
      isf_pkg::ADDR_GYRO_Z_TRIM:   rd_value = trim_ff[2];
      isf_pkg::ADDR_SAMPLE_PERIOD: rd_value = sample_period_ff;
      isf_pkg::ADDR_RANGE_FILTER:  rd_value = range_filter_ff;
      default:                     rd_value = 16'h0000;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      REG_RDATA <= rd_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock: internal divider or rising edge of pin four
  logic [31:0] div_ff;
  logic        pin_prev_ff;
  logic        tick;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_ff <= '0;
    end else if (!clk_internal || div_ff == 32'(TICK_CYCLES - 1)) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 32'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= GENERAL_PIN_FOUR_I;
    end
  end

  // The fractional part of the ideal period is dropped, so the rate runs slightly fast
  assign tick = clk_internal ? (div_ff == 32'(TICK_CYCLES - 1))
                             : (GENERAL_PIN_FOUR_I && !pin_prev_ff);
  assign SAMPLE_TICK = tick;

  // External clocking takes the pin away from the general-purpose controls
  assign GENERAL_PIN_FOUR_OE = clk_internal & PIN_FOUR_DIR;
  assign GENERAL_PIN_FOUR_O  = clk_internal & PIN_FOUR_LEVEL;

  ////////////////////////////////////////////////////////////////////////////
  // Filter per axis; any filter setting change flushes history to avoid mixed windows
  logic        clear_ff;
  logic [7:0]  setting_q_ff;
  logic [15:0] raw [0:isf_pkg::AXES-1];
  logic [15:0] filt [0:isf_pkg::AXES-1];
  logic        filt_v [0:isf_pkg::AXES-1];
  logic [15:0] result_ff [0:isf_pkg::AXES-1];
  logic        result_v_ff;

  assign raw[0] = GYRO_X_RAW;
  assign raw[1] = GYRO_Y_RAW;
  assign raw[2] = GYRO_Z_RAW;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      setting_q_ff <= 8'h00;
      clear_ff     <= 1'b1;
    end else begin
      setting_q_ff <= {taps_log2, decim};
      clear_ff     <= setting_q_ff != {taps_log2, decim};
    end
  end

  for (a = 0; a < isf_pkg::AXES; a++) begin : g_axis
    isf_axis_filter u_filter (
      .clk          (MCLK),
      .rst_n        (RESET_N),
      .clear        (clear_ff),
      .sample_valid (tick),
      .sample       (raw[a]),
      .taps_log2    (taps_log2),
      .decim_log2   (decim),
      .out_valid    (filt_v[a]),
      .out_data     (filt[a])
    );
    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        result_ff[a] <= '0;
      end else if (filt_v[a]) begin
        // Trim is sign-extended from 14 bits and joins the sum at the output load
        result_ff[a] <= filt[a] + {{2{trim_ff[a][isf_pkg::TRIM_W-1]}}, trim_ff[a][isf_pkg::TRIM_W-1:0]};
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      result_v_ff <= 1'b0;
    end else begin
      result_v_ff <= filt_v[0];
    end
  end

  assign GYRO_X_RESULT = result_ff[0];
  assign GYRO_Y_RESULT = result_ff[1];
  assign GYRO_Z_RESULT = result_ff[2];
  assign RESULT_VALID  = result_v_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  property p_int_spacing;
    tick && clk_internal ##1 clk_internal [*8] |-> !$past(tick);
  endproperty
  a_int_spacing: assert property (p_int_spacing) else $error("internal ticks too close");

  property p_int_period;
    clk_internal && $past(clk_internal) && div_ff == 32'h0 && $past(div_ff) != 32'h0 |-> $past(tick);
  endproperty
  a_int_period: assert property (p_int_period) else $error("divider restarted without a tick");

  property p_ext_edge;
    !clk_internal && $rose(GENERAL_PIN_FOUR_I) |-> tick;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external edge missed");

  property p_pin_owned;
    !clk_internal |-> !GENERAL_PIN_FOUR_OE && !GENERAL_PIN_FOUR_O;
  endproperty
  a_pin_owned: assert property (p_pin_owned) else $error("pin four driven in external mode");

  property p_range_legal;
    cur_range == isf_pkg::RANGE_300 || cur_range == isf_pkg::RANGE_150 || cur_range == isf_pkg::RANGE_75;
  endproperty
  a_range_legal: assert property (p_range_legal) else $error("illegal range stored");

  property p_min_taps;
    (cur_range != isf_pkg::RANGE_75 || taps_log2 >= isf_pkg::MIN_TAPS_75) &&
    (cur_range != isf_pkg::RANGE_150 || taps_log2 >= isf_pkg::MIN_TAPS_150);
  endproperty
  a_min_taps: assert property (p_min_taps) else $error("filter below range minimum");

  property p_trim_add;
    filt_v[1] |=> g_axis[1].u_filter.out_data == $past(filt[1]) &&
                  result_ff[1] == 16'($past(filt[1]) + {{2{$past(trim_ff[1][13])}}, $past(trim_ff[1][13:0])});
  endproperty
  a_trim_add: assert property (p_trim_add) else $error("trim not added at output load");

  property p_unused_zero;
    REG_RD |=> (REG_RDATA & ~(isf_pkg::MASK_SAMPLE_PERIOD | isf_pkg::MASK_RANGE_FILTER | isf_pkg::MASK_TRIM)) == 16'h0000
               && ($past(REG_ADDR) != isf_pkg::ADDR_SAMPLE_PERIOD || (REG_RDATA & ~isf_pkg::MASK_SAMPLE_PERIOD) == 16'h0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

  c_ext_tick:   cover property (!clk_internal && tick);
  c_range_75:   cover property (cur_range == isf_pkg::RANGE_75);
  c_result:     cover property (RESULT_VALID && decim != 5'h00);
endmodule

// *** sim/isf_host_model.sv ***
// Host model: drives the register port of the sample filter block.
// Assumes one calling process; each access is a one-cycle strobe.
`timescale 1ns/1ps
module isf_host_model (
  input  wire logic  clk,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [1:0] reg_be,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_be    = 2'h0;
    reg_wdata = 16'h0000;
  end

  // Request changes after a falling edge, is taken at the rising edge between
  task automatic drive(input logic w, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk);
    reg_wr    <= w;
    reg_rd    <= ~w;
    reg_addr  <= a;
    reg_be    <= be;
    reg_wdata <= d;
    @(negedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    // Released address and data lines show the inverse so a stale value cannot pass for a live one
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

// *** sim/tb_imu_sample_filter_bias_trim.sv ***
// Self-checking bench for the gyroscope sample path.
// Assumes isf_top with a shortened tick divider; the bench plays the pin-four clock source.
`timescale 1ns/1ps
module tb_imu_sample_filter_bias_trim;
  localparam int TICKS = 16;
  localparam logic [41:0] TBL [13] = '{
    {8'h1e, 2'h3, 16'hffff, 16'h3fff}, {8'h20, 2'h3, 16'hc001, 16'h0001},
    {8'h22, 2'h3, 16'h8000, 16'h0000}, {8'h3a, 2'h3, 16'hffff, 16'h1f01},
    {8'h3a, 2'h3, 16'h0001, 16'h0001}, {8'h3c, 2'h3, 16'hffff, 16'h0407},
    {8'h3c, 2'h3, 16'h0200, 16'h0202}, {8'h3c, 2'h1, 16'h0001, 16'h0202},
    {8'h3c, 2'h3, 16'h0100, 16'h0104}, {8'h3c, 2'h3, 16'h0106, 16'h0106},
    {8'h3c, 2'h2, 16'h0400, 16'h0406}, {8'h3c, 2'h3, 16'h0300, 16'h0400},
    {8'h24, 2'h3, 16'hffff, 16'h0000}};
  localparam logic [15:0] BX [4] = '{16'h0002, 16'h0006, 16'h0008, 16'h0008};

  logic        mclk, reset_n, reg_wr, reg_rd, pin_dir, pin_lvl, pin_in, ext_clk;
  logic        pin_o, pin_oe, tick, res_v, rd_seen, track;
  logic [7:0]  reg_addr;
  logic [1:0]  reg_be;
  logic [15:0] reg_wdata, reg_rdata, raw_x, raw_y, raw_z, res_x, res_y, res_z, x, y, z;
  logic [15:0] trim [3];
  logic [15:0] rd_q [$];
  logic [47:0] res_q [$];
  logic [47:0] e;
  logic [31:0] lfsr;
  int          errors, check_count, cycles, n, i, k;

  // Pin four level: whoever has its enable up owns the wire
  assign pin_in = (pin_oe === 1'b1) ? pin_o : ext_clk;

  isf_host_model host_u (.clk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wdata(reg_wdata));

  isf_top #(.TICK_CYCLES(TICKS)) dut_u (.MCLK(mclk), .RESET_N(reset_n), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_BE(reg_be), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .GYRO_X_RAW(raw_x), .GYRO_Y_RAW(raw_y), .GYRO_Z_RAW(raw_z),
    .PIN_FOUR_DIR(pin_dir), .PIN_FOUR_LEVEL(pin_lvl), .GENERAL_PIN_FOUR_I(pin_in),
    .GENERAL_PIN_FOUR_O(pin_o), .GENERAL_PIN_FOUR_OE(pin_oe), .SAMPLE_TICK(tick),
    .GYRO_X_RESULT(res_x), .GYRO_Y_RESULT(res_y), .GYRO_Z_RESULT(res_z), .RESULT_VALID(res_v));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] sx(input logic [15:0] t);
    return {{2{t[13]}}, t[13:0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    host_u.drive(1'b1, a, be, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    host_u.drive(1'b0, a, 2'h0, 16'h0000);
  endtask

  task automatic expect3(input logic [15:0] ex, input logic [15:0] ey, input logic [15:0] ez);
    res_q.push_back({ex + sx(trim[0]), ey + sx(trim[1]), ez + sx(trim[2])});
  endtask

  // Ticks stay nine cycles apart, the pin high for four and low for five
  task automatic ext_tick(input logic [15:0] tx, input logic [15:0] ty, input logic [15:0] tz);
    @(negedge mclk);
    raw_x   = tx;
    raw_y   = ty;
    raw_z   = tz;
    ext_clk = 1'b1;
    repeat (4) @(negedge mclk);
    ext_clk = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    rd_seen <= reg_rd;
    cycles++;
    if (cycles == 6000) begin
      errors++;
      $display("mismatch at %0t: run did not finish", $time);
      complete_run();
    end
  end

  // Watcher: every read answer and every tracked result takes the oldest note
  always @(negedge mclk) begin
    if (rd_seen === 1'b1) begin
      if (rd_q.size() == 0) begin
        errors++;
        $display("mismatch at %0t: read answer with nothing expected", $time);
      end else begin
        check(reg_rdata, rd_q.pop_front(), "register read");
      end
    end
    if (res_v === 1'b1 && track === 1'b1) begin
      if (res_q.size() == 0) begin
        errors++;
        $display("mismatch at %0t: result with nothing expected", $time);
      end else begin
        e = res_q.pop_front();
        check(res_x, e[47:32], "x result");
        check(res_y, e[31:16], "y result");
        check(res_z, e[15:0], "z result");
      end
    end
  end

  initial begin
    reset_n = 1'b0;
    pin_dir = 1'b1;
    pin_lvl = 1'b1;
    ext_clk = 1'b0;
    raw_x   = 16'h0000;
    raw_y   = 16'h0000;
    raw_z   = 16'h0000;
    track   = 1'b0;
    rd_seen = 1'b0;
    lfsr    = 32'hf1e1ab60;
    trim    = '{16'h0000, 16'h0000, 16'h0000};
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    rd(8'h1e, 16'h0000);
    rd(8'h20, 16'h0000);
    rd(8'h22, 16'h0000);
    rd(8'h3a, 16'h0001);
    rd(8'h3c, 16'h0402);
    check(16'(pin_oe), 16'h0001, "pin enable internal");
    check(16'(pin_o), 16'h0001, "pin level internal");
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tick !== 1'b1 && n < 100);
    check(16'(n), 16'(TICKS), "internal tick period");
    for (i = 0; i < 13; i++) begin
      wr(TBL[i][41:34], TBL[i][33:32], TBL[i][31:16]);
      rd(TBL[i][41:34], TBL[i][15:0]);
    end
    wr(8'h3a, 2'h3, 16'h0000);
    repeat (4) @(negedge mclk);
    check(16'(pin_oe), 16'h0000, "pin enable external");
    check(16'(pin_o), 16'h0000, "pin level external");
    pin_dir = 1'b0;
    n = 0;
    repeat (3 * TICKS) begin
      @(negedge mclk);
      if (tick === 1'b1) n++;
    end
    check(16'(n), 16'h0000, "no internal tick");
    for (i = 0; i < 3; i++) begin
      lfsr    = nxt(lfsr);
      trim[i] = {2'b00, lfsr[13:0]};
      wr(8'h1e + 8'(2 * i), 2'h3, lfsr[15:0]);
    end
    repeat (8) @(negedge mclk);
    track = 1'b1;
    for (k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      x    = lfsr[15:0];
      y    = lfsr[31:16];
      lfsr = nxt(lfsr);
      z    = lfsr[15:0];
      expect3(x, y, z);
      ext_tick(x, y, z);
    end
    wr(8'h3a, 2'h3, 16'h0200);
    repeat (8) @(negedge mclk);
    for (k = 0; k < 2; k++) begin
      lfsr = nxt(lfsr);
      x    = {4'h0, lfsr[11:0]};
      y    = 16'h0000 - {4'h0, lfsr[27:16]};
      // Four distinct samples per group, so only a true mean lands on the middle value
      expect3(x + 16'h0003, y + 16'h0003, 16'h0003);
      for (i = 0; i < 4; i++) ext_tick(x + 16'(2 * i), y + 16'(2 * i), 16'(2 * i));
    end
    wr(8'h3a, 2'h3, 16'h0000);
    wr(8'h3c, 2'h3, 16'h0401);
    repeat (8) @(negedge mclk);
    for (k = 0; k < 4; k++) begin
      expect3(BX[k], 16'h0000 - BX[k], BX[k] << 1);
      ext_tick(16'h0008, 16'hfff8, 16'h0010);
    end
    repeat (8) @(negedge mclk);
    check(16'(res_q.size()), 16'h0000, "results left over");
    track   = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    rd(8'h3a, 16'h0001);
    rd(8'h1e, 16'h0000);
    pin_lvl = 1'b0;
    pin_dir = 1'b1;
    repeat (4) @(negedge mclk);
    check(16'({pin_oe, pin_o}), 16'h0002, "pin controls after reset");
    complete_run();
  end
endmodule
